/* File: fcl_flash_seq.v */
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`include "fcl_map.vh"
module fcl_flash_seq #(
  parameter [7:0] ENGINE_TICKS = `FCL_ENGINE_TICKS
) (
  input  wire        clk,              // Clock, 10 MHz
  input  wire        srst,             // Sync reset, active high
  input  wire [3:0]  addr,             // Register word address
  input  wire [15:0] wdata,            // Write data
  input  wire        wr,               // Write strobe
  input  wire        rd,               // Read strobe
  output reg  [15:0] rdata,            // Read data, cycle after rd
  input  wire [1:0]  mode,             // Operating mode
  input  wire        secured,          // Device secured
  input  wire [63:0] backdoor_key,     // Stored backdoor key
  output reg         timebase_tick,    // Flash time-base tick
  output wire        engine_busy,      // Command executing
  output reg  [7:0]  engine_code,      // Command held by engine
  output reg  [22:0] engine_addr,      // Global address held by engine
  output reg  [15:0] user_margin,      // User margin level
  output reg  [15:0] field_margin,     // Field margin level
  output reg         security_release  // Security released
);

  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_RUN    = 3'h1;
  localparam [2:0] S_WRONCE = 3'h2;
  localparam [2:0] S_RDONCE = 3'h3;

  function cmd_permitted;
    input [7:0] code;
    input [1:0] md;
    input       sec;
    reg         special;
    reg         sec_ns;
    begin
      special = (md == `FCL_MODE_SS) || (md == `FCL_MODE_ST);
      sec_ns  = sec && (md == `FCL_MODE_NS);
      case (code)
        `FCL_CMD_EVALL, `FCL_CMD_EVBLK: cmd_permitted = 1'b1;
        `FCL_CMD_EVPSEC, `FCL_CMD_RDONCE, `FCL_CMD_PGMD: cmd_permitted = !sec || sec_ns;
        `FCL_CMD_PGMP, `FCL_CMD_PGMONCE, `FCL_CMD_ERSBLK, `FCL_CMD_ERSPSEC,
        `FCL_CMD_UMARGIN, `FCL_CMD_EVDSEC, `FCL_CMD_ERSDSEC:
          cmd_permitted = (!sec && (md != `FCL_MODE_NS)) || sec_ns;
        `FCL_CMD_ERSALL, `FCL_CMD_UNSEC: cmd_permitted = special;
        `FCL_CMD_BDKEY: cmd_permitted = sec_ns;
        `FCL_CMD_FMARGIN: cmd_permitted = !sec && special;
        default: cmd_permitted = 1'b0;
      endcase
    end
  endfunction

  function is_prog_erase;
    input [7:0] code;
    begin
      case (code)
        `FCL_CMD_PGMP, `FCL_CMD_PGMONCE, `FCL_CMD_ERSALL, `FCL_CMD_ERSBLK,
        `FCL_CMD_ERSPSEC, `FCL_CMD_UNSEC, `FCL_CMD_PGMD, `FCL_CMD_ERSDSEC:
          is_prog_erase = 1'b1;
        default: is_prog_erase = 1'b0;
      endcase
    end
  endfunction

  reg  [6:0]  div_ratio;
  reg         div_loaded;
  reg  [6:0]  div_cnt;
  reg  [2:0]  param_index;
  reg  [7:0]  pprot;
  reg  [7:0]  dprot;
  reg         command_complete_flag;
  reg         access_error_flag;
  reg         protection_violation_flag;
  reg  [15:0] param [0:5];
  reg  [2:0]  state;
  reg  [7:0]  tick_cnt;
  reg  [2:0]  step;
  reg  [2:0]  eng_phrase;
  reg  [63:0] eng_data;
  reg  [7:0]  once_done;
  reg  [15:0] next_rdata;
  integer     i;

  wire        wr_status  = wr && (addr == `FCL_OFS_STATUS);
  wire        launch_req = wr_status && wdata[`FCL_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag && !access_error_flag && !protection_violation_flag;
  wire [7:0]  cmd_code   = param[0][15:8];
  wire [63:0] cmd_data   = {param[2], param[3], param[4], param[5]};
  wire [2:0]  cmd_phrase = param[1][2:0];
  wire        pflash_open = pprot[`FCL_PLDIS_BIT] && pprot[`FCL_PHDIS_BIT] && pprot[`FCL_POPEN_BIT];
  // Errors are judged at launch so nothing invalid ever reaches the engine
  wire        bad_cmd    = !cmd_permitted(cmd_code, mode, secured);
  wire        no_div     = is_prog_erase(cmd_code) && !div_loaded;
  wire        once_again = (cmd_code == `FCL_CMD_PGMONCE) && once_done[cmd_phrase];
  wire        key_bad    = (cmd_code == `FCL_CMD_BDKEY) && (cmd_data != backdoor_key);
  wire        acc_cond   = bad_cmd || no_div || once_again || key_bad;
  wire        pv_cond    = ((cmd_code == `FCL_CMD_ERSALL) && !(pflash_open && dprot[`FCL_DOPEN_BIT])) ||
                           ((cmd_code == `FCL_CMD_ERSBLK) && !pflash_open);
  wire        launch_ok  = launch_req && !acc_cond && !pv_cond;
  wire        run_done   = (state == S_RUN) && timebase_tick && (tick_cnt == ENGINE_TICKS - 8'h01);
  wire        once_mem_wr = (state == S_WRONCE);
  wire [4:0]  once_wr_addr = {eng_phrase, step[1:0]};
  wire [15:0] once_wr_data = eng_data[63 - 16 * step[1:0] -: 16];
  wire        once_rd_en = (state == S_RDONCE) && (step < 3'h4);
  wire [15:0] once_rd_data;
  // Unprogrammed phrases read as erased rather than stale memory contents
  wire [15:0] once_word = once_done[eng_phrase] ? once_rd_data : `FCL_ERASED_WORD;

  assign engine_busy = !command_complete_flag;

  fcl_once_mem u_once_mem (
    .clk     (clk),
    .srst    (srst),
    .wr_en   (once_mem_wr),
    .wr_addr (once_wr_addr),
    .wr_data (once_wr_data),
    .rd_en   (once_rd_en),
    .rd_addr ({eng_phrase, step[1:0]}),
    .rd_data (once_rd_data)
  );

  // Time base; ratio n gives one tick every n+1 bus clocks
  always @(posedge clk) begin
    if (srst) begin
      div_cnt       <= 7'h00;
      timebase_tick <= 1'b0;
    end else if (div_cnt >= div_ratio) begin
      div_cnt       <= 7'h00;
      timebase_tick <= 1'b1;
    end else begin
      div_cnt       <= div_cnt + 7'h01;
      timebase_tick <= 1'b0;
    end
  end

  // Configuration registers
  always @(posedge clk) begin
    if (srst) begin
      div_ratio   <= `FCL_RST_DIV;
      div_loaded  <= 1'b0;
      param_index <= `FCL_RST_INDEX;
      pprot       <= `FCL_RST_PROT;
      dprot       <= `FCL_RST_PROT;
    end else if (wr) begin
      case (addr)
        `FCL_OFS_CLKDIV: begin
          div_ratio  <= wdata[6:0];
          div_loaded <= 1'b1;
        end
        `FCL_OFS_INDEX: param_index <= wdata[2:0];
        `FCL_OFS_PPROT: pprot <= wdata[7:0];
        `FCL_OFS_DPROT: dprot <= wdata[7:0];
        default: ;
      endcase
    end
  end

  // Error flags: write one clears, a new error in the same cycle wins
  always @(posedge clk) begin
    if (srst) begin
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else begin
      if (launch_req && acc_cond) begin
        access_error_flag <= 1'b1;
      end else if (wr_status && wdata[`FCL_ACCESS_ERROR_FLAG_BIT]) begin
        access_error_flag <= 1'b0;
      end
      if (launch_req && !acc_cond && pv_cond) begin
        protection_violation_flag <= 1'b1;
      end else if (wr_status && wdata[`FCL_PROTECTION_VIOLATION_FLAG_BIT]) begin
        protection_violation_flag <= 1'b0;
      end
    end
  end

  // Parameter array and command engine
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < `FCL_PARAM_WORDS; i = i + 1) begin
        param[i] <= `FCL_RST_WORD;
      end
      command_complete_flag             <= 1'b1;
      state            <= S_IDLE;
      tick_cnt         <= 8'h00;
      step             <= 3'h0;
      eng_phrase       <= 3'h0;
      eng_data         <= 64'h0000000000000000;
      engine_code      <= 8'h00;
      engine_addr      <= 23'h000000;
      once_done        <= 8'h00;
      user_margin      <= `FCL_RST_WORD;
      field_margin     <= `FCL_RST_WORD;
      security_release <= 1'b0;
    end else begin
      if (wr && (addr == `FCL_OFS_PARAM) && command_complete_flag && (param_index < 3'h6)) begin
        param[param_index] <= wdata;
      end
      case (state)
        S_IDLE: begin
          if (launch_ok) begin
            command_complete_flag        <= 1'b0;
            engine_code <= cmd_code;
            engine_addr <= {param[0][6:0], param[1]};
            eng_data    <= cmd_data;
            eng_phrase  <= cmd_phrase;
            tick_cnt    <= 8'h00;
            step        <= 3'h0;
            if (cmd_code == `FCL_CMD_RDONCE) begin
              state <= S_RDONCE;
            end else if (cmd_code == `FCL_CMD_PGMONCE) begin
              state <= S_WRONCE;
            end else begin
              state <= S_RUN;
            end
          end
        end
        S_WRONCE: begin
          if (step == 3'h3) begin
            once_done[eng_phrase] <= 1'b1;
            state                 <= S_RUN;
          end
          step <= step + 3'h1;
        end
        S_RDONCE: begin
          if (step != 3'h0) begin
            param[step + 3'h1] <= once_word;
          end
          if (step == 3'h4) begin
            command_complete_flag  <= 1'b1;
            state <= S_IDLE;
          end
          step <= step + 3'h1;
        end
        S_RUN: begin
          // Array timing is modelled as a fixed count of time-base ticks
          if (timebase_tick) begin
            tick_cnt <= tick_cnt + 8'h01;
          end
          if (run_done) begin
            command_complete_flag  <= 1'b1;
            state <= S_IDLE;
            case (engine_code)
              `FCL_CMD_UMARGIN: user_margin <= eng_data[63:48];
              `FCL_CMD_FMARGIN: field_margin <= eng_data[63:48];
              `FCL_CMD_UNSEC, `FCL_CMD_BDKEY: security_release <= 1'b1;
              default: ;
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Read mux
  always @* begin
    next_rdata = 16'h0000;
    case (addr)
      `FCL_OFS_CLKDIV: next_rdata = {8'h00, div_loaded, div_ratio};
      `FCL_OFS_INDEX:  next_rdata = {13'h0000, param_index};
      `FCL_OFS_STATUS: next_rdata = {8'h00, command_complete_flag, 1'b0, access_error_flag, protection_violation_flag, 4'h0};
      `FCL_OFS_PPROT:  next_rdata = {8'h00, pprot};
      `FCL_OFS_DPROT:  next_rdata = {8'h00, dprot};
      `FCL_OFS_PARAM:  next_rdata = (param_index < 3'h6) ? param[param_index] : 16'h0000;
      `FCL_OFS_MARGIN: next_rdata = {user_margin[7:0], field_margin[7:0]};
      default:         next_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule // fcl_flash_seq

/* File: fcl_map.vh */
`ifndef FCL_MAP_VH
`define FCL_MAP_VH

// Register offsets (word addresses on the 4-bit register port)
`define FCL_OFS_CLKDIV      4'h0
`define FCL_OFS_INDEX       4'h1
`define FCL_OFS_STATUS      4'h2
`define FCL_OFS_PPROT       4'h3
`define FCL_OFS_DPROT       4'h4
`define FCL_OFS_PARAM       4'h5
`define FCL_OFS_MARGIN      4'h6

// Field positions
`define FCL_DIVLD_BIT       7
`define FCL_COMMAND_COMPLETE_FLAG_BIT        7
`define FCL_ACCESS_ERROR_FLAG_BIT      5
`define FCL_PROTECTION_VIOLATION_FLAG_BIT      4
`define FCL_PLDIS_BIT       2
`define FCL_PHDIS_BIT       5
`define FCL_POPEN_BIT       7
`define FCL_DOPEN_BIT       7

// Reset values
`define FCL_RST_DIV         7'h00
`define FCL_RST_INDEX       3'h0
`define FCL_RST_PROT        8'h00
`define FCL_RST_WORD        16'h0000
`define FCL_ERASED_WORD     16'hffff

// Parameter array
`define FCL_PARAM_WORDS     6
`define FCL_ONCE_PHRASES    8

// Operating modes
`define FCL_MODE_NS         2'h0
`define FCL_MODE_NX         2'h1
`define FCL_MODE_SS         2'h2
`define FCL_MODE_ST         2'h3

// Command codes
`define FCL_CMD_EVALL       8'h01
`define FCL_CMD_EVBLK       8'h02
`define FCL_CMD_EVPSEC      8'h03
`define FCL_CMD_RDONCE      8'h04
`define FCL_CMD_PGMP        8'h06
`define FCL_CMD_PGMONCE     8'h07
`define FCL_CMD_ERSALL      8'h08
`define FCL_CMD_ERSBLK      8'h09
`define FCL_CMD_ERSPSEC     8'h0a
`define FCL_CMD_UNSEC       8'h0b
`define FCL_CMD_BDKEY       8'h0c
`define FCL_CMD_UMARGIN     8'h0d
`define FCL_CMD_FMARGIN     8'h0e
`define FCL_CMD_EVDSEC      8'h10
`define FCL_CMD_PGMD        8'h11
`define FCL_CMD_ERSDSEC     8'h12

// Timing: engine run length in flash time-base ticks
`define FCL_ENGINE_TICKS    8'h10

`endif

/* File: fcl_once_mem.v */
`timescale 1ns/1ps
module fcl_once_mem (
  input  wire        clk,     // Clock
  input  wire        srst,    // Sync reset
  input  wire        wr_en,   // Write enable
  input  wire [4:0]  wr_addr, // Write word address
  input  wire [15:0] wr_data, // Write data
  input  wire        rd_en,   // Read enable
  input  wire [4:0]  rd_addr, // Read word address
  output reg  [15:0] rd_data  // Registered read data
);

  reg [15:0] mem [0:31];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // fcl_once_mem

/* File: fcl_flash_seq_assertions.sv */
`timescale 1ns/1ps
module fcl_flash_seq_chk #(
  parameter [7:0] ENGINE_TICKS = 8'h10
) (
  input wire        clk,             // Clock
  input wire        srst,            // Sync reset
  input wire [3:0]  addr,            // Register address
  input wire [15:0] wdata,           // Write data
  input wire        wr,              // Write strobe
  input wire [1:0]  mode,            // Operating mode
  input wire        secured,         // Secured
  input wire        engine_busy,     // Busy
  input wire [7:0]  engine_code,     // Engine code
  input wire [15:0] user_margin,     // User level
  input wire [15:0] field_margin,    // Field level
  input wire        security_release // Released
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_launch_cause: assert property ($rose(engine_busy) |-> $past(wr && addr == 4'h2 && wdata[7]))
    else $error("busy rose without launch write");
  a_code_hold: assert property (engine_busy && $past(engine_busy) |-> $stable(engine_code))
    else $error("engine code moved during run");
  a_busy_bound: assert property ($rose(engine_busy) |-> ##[1:1000] !engine_busy)
    else $error("run never completed");
  a_erase_mode: assert property ($rose(engine_busy) && (engine_code == 8'h08 || engine_code == 8'h0b) |-> mode[1])
    else $error("erase all or unsecure in normal mode");
  a_key_mode: assert property ($rose(engine_busy) && engine_code == 8'h0c |-> secured && mode == 2'h0)
    else $error("key command outside secured normal mode");
  a_field_mode: assert property ($changed(field_margin) |-> mode[1] && !secured)
    else $error("field level set outside special mode");
  a_user_cause: assert property ($changed(user_margin) |-> $fell(engine_busy) && engine_code == 8'h0d)
    else $error("user level changed without command");
  a_release_hold: assert property ($past(security_release) |-> security_release)
    else $error("security release dropped");
  a_release_cause: assert property ($rose(security_release) |-> $fell(engine_busy)
    && (engine_code == 8'h0b || engine_code == 8'h0c))
    else $error("security released without command");
endmodule // fcl_flash_seq_chk

bind fcl_flash_seq fcl_flash_seq_chk #(.ENGINE_TICKS(ENGINE_TICKS)) u_chk (.clk(clk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr(wr), .mode(mode), .secured(secured), .engine_busy(engine_busy), .engine_code(engine_code),
  .user_margin(user_margin), .field_margin(field_margin), .security_release(security_release));

/* File: fcl_flash_seq_tb_top.sv */
`timescale 1ns/1ps
`include "fcl_map.vh"
module fcl_flash_seq_tb_top;
  reg         clk;
  reg         srst;
  reg  [3:0]  addr;
  reg  [15:0] wdata;
  reg         wr;
  reg         rd;
  reg  [1:0]  mode;
  reg         secured;
  reg  [63:0] backdoor_key;
  wire [15:0] rdata;
  wire        engine_busy;
  wire [7:0]  engine_code;
  wire [22:0] engine_addr;
  wire        timebase_tick;
  wire [15:0] user_margin;
  wire [15:0] field_margin;
  wire        security_release;
  integer     n_fail;
  integer     cmp_count;
  integer     i;
  integer     j;
  integer     k;
  // Code list and acceptance mask, bit = secured*4 + mode
  localparam [127:0] CODES = 128'h0c_01_02_04_06_08_0b_0d_0e_11_05_03_09_0a_10_12;
  localparam [127:0] MASKS = 128'h10_ff_ff_1f_1e_cc_cc_1e_0c_1f_00_1f_1e_1e_1e_1e;

  fcl_flash_seq #(.ENGINE_TICKS(8'h02)) i_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .mode(mode), .secured(secured), .backdoor_key(backdoor_key),
    .timebase_tick(timebase_tick), .engine_busy(engine_busy), .engine_code(engine_code),
    .engine_addr(engine_addr), .user_margin(user_margin), .field_margin(field_margin),
    .security_release(security_release));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task chk(input [63:0] e, input [63:0] g, input [8*8:1] nm);
    begin
      cmp_count++;
      if (g !== e) begin
        n_fail++;
        $display("unexpected %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // Gap cycle after each strobe keeps one assignment per step
  task wr_reg(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  task rd_chk(input [3:0] a, input [15:0] e, input [8*8:1] nm);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(e, rdata, nm);
    end
  endtask

  task wait_idle;
    begin
      k = 0;
      while (engine_busy !== 1'b0 && k < 2000) begin
        @(negedge clk);
        k++;
      end
      chk(1'b0, engine_busy, "idle");
    end
  endtask

  task launch(input [7:0] c);
    begin
      wr_reg(`FCL_OFS_INDEX, 16'h0000);
      wr_reg(`FCL_OFS_PARAM, {c, 8'h00});
      wr_reg(`FCL_OFS_STATUS, 16'h0080);
      @(negedge clk);
    end
  endtask

  task t_reset_nodiv;
    begin
      rd_chk(`FCL_OFS_CLKDIV, 16'h0000, "divider");
      chk(1'b0, security_release, "release");
      rd_chk(`FCL_OFS_STATUS, 16'h0080, "status");
      mode <= `FCL_MODE_NX;
      launch(8'h06);
      rd_chk(`FCL_OFS_STATUS, 16'h00a0, "status");
      wr_reg(`FCL_OFS_STATUS, 16'h0020);
      rd_chk(`FCL_OFS_STATUS, 16'h0080, "status");
      wr_reg(`FCL_OFS_CLKDIV, 16'h0003);
      rd_chk(`FCL_OFS_CLKDIV, 16'h0083, "divider");
      $display("test reset and divider done");
    end
  endtask

  task t_index;
    begin
      for (i = 0; i < 8; i++) begin
        wr_reg(`FCL_OFS_INDEX, i[15:0]);
        wr_reg(`FCL_OFS_PARAM, 16'h1110 + i[15:0]);
      end
      for (i = 0; i < 8; i++) begin
        wr_reg(`FCL_OFS_INDEX, i[15:0]);
        rd_chk(`FCL_OFS_PARAM, (i < 6) ? 16'h1110 + i[15:0] : 16'h0000, "param");
      end
      $display("test index done");
    end
  endtask

  task t_busy;
    begin
      wr_reg(`FCL_OFS_INDEX, 16'h0000);
      wr_reg(`FCL_OFS_PARAM, 16'h0201);
      wr_reg(`FCL_OFS_INDEX, 16'h0001);
      wr_reg(`FCL_OFS_PARAM, 16'h2345);
      wr_reg(`FCL_OFS_STATUS, 16'h0080);
      @(negedge clk);
      chk(1'b1, engine_busy, "busy");
      chk(8'h02, engine_code, "code");
      chk(23'h012345, engine_addr, "address");
      wr_reg(`FCL_OFS_PARAM, 16'hdead);
      rd_chk(`FCL_OFS_STATUS, 16'h0000, "status");
      wait_idle;
      rd_chk(`FCL_OFS_PARAM, 16'h2345, "param");
      rd_chk(`FCL_OFS_STATUS, 16'h0080, "status");
      $display("test busy done");
    end
  endtask

  task t_modes;
    begin
      wr_reg(`FCL_OFS_PPROT, 16'h00a4);
      wr_reg(`FCL_OFS_DPROT, 16'h0080);
      for (i = 0; i < 16; i++) begin
        for (j = 0; j < 8; j++) begin
          secured <= j[2];
          mode <= j[1:0];
          launch(CODES[8*(15-i)+:8]);
          chk(MASKS[8*(15-i)+j], engine_busy, "accept");
          if (MASKS[8*(15-i)+j] == 1'b0) begin
            rd_chk(`FCL_OFS_STATUS, 16'h00a0, "status");
            wr_reg(`FCL_OFS_STATUS, 16'h0020);
          end
          wait_idle;
        end
      end
      chk(1'b1, security_release, "release");
      $display("test modes done");
    end
  endtask

  task t_prot;
    begin
      wr_reg(`FCL_OFS_PPROT, 16'h0000);
      secured <= 1'b0;
      mode <= `FCL_MODE_SS;
      for (i = 0; i < 2; i++) begin
        launch(8'h08 + i[7:0]);
        rd_chk(`FCL_OFS_STATUS, 16'h0090, "status");
        wr_reg(`FCL_OFS_STATUS, 16'h0010);
      end
      // Data flash closed: erase-all refused, block erase still runs
      wr_reg(`FCL_OFS_PPROT, 16'h00a4);
      wr_reg(`FCL_OFS_DPROT, 16'h0000);
      launch(8'h08);
      rd_chk(`FCL_OFS_STATUS, 16'h0090, "status");
      wr_reg(`FCL_OFS_STATUS, 16'h0010);
      launch(8'h09);
      chk(1'b1, engine_busy, "busy");
      wait_idle;
      $display("test protection done");
    end
  endtask

  task t_engine;
    begin
      for (i = 2; i < 6; i++) begin
        wr_reg(`FCL_OFS_INDEX, i[15:0]);
        wr_reg(`FCL_OFS_PARAM, 16'ha000 + i[15:0]);
      end
      wr_reg(`FCL_OFS_INDEX, 16'h0001);
      wr_reg(`FCL_OFS_PARAM, 16'h0002);
      launch(8'h07);
      chk(1'b1, engine_busy, "busy");
      wait_idle;
      for (i = 2; i < 6; i++) begin
        wr_reg(`FCL_OFS_INDEX, i[15:0]);
        wr_reg(`FCL_OFS_PARAM, 16'h0000);
      end
      launch(8'h04);
      wait_idle;
      for (i = 2; i < 6; i++) begin
        wr_reg(`FCL_OFS_INDEX, i[15:0]);
        rd_chk(`FCL_OFS_PARAM, 16'ha000 + i[15:0], "once");
      end
      launch(8'h07);
      rd_chk(`FCL_OFS_STATUS, 16'h00a0, "status");
      wr_reg(`FCL_OFS_STATUS, 16'h0020);
      wr_reg(`FCL_OFS_INDEX, 16'h0001);
      wr_reg(`FCL_OFS_PARAM, 16'h0003);
      launch(8'h04);
      wait_idle;
      wr_reg(`FCL_OFS_INDEX, 16'h0002);
      rd_chk(`FCL_OFS_PARAM, 16'hffff, "once");
      wr_reg(`FCL_OFS_PARAM, 16'h12a5);
      launch(8'h0d);
      wait_idle;
      wr_reg(`FCL_OFS_INDEX, 16'h0002);
      wr_reg(`FCL_OFS_PARAM, 16'h345a);
      launch(8'h0e);
      wait_idle;
      chk(16'h12a5, user_margin, "user");
      chk(16'h345a, field_margin, "field");
      rd_chk(`FCL_OFS_MARGIN, 16'ha55a, "margin");
      // Divider holds 3 from the first test, so one tick every 4 clocks
      k = 0;
      while (timebase_tick !== 1'b1 && k < 20) begin
        @(negedge clk);
        k++;
      end
      @(negedge clk);
      k = 1;
      while (timebase_tick !== 1'b1 && k < 20) begin
        @(negedge clk);
        k++;
      end
      chk(8'h04, k, "tick");
      $display("test engine done");
    end
  endtask

  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial begin
    #2000000;
    n_fail++;
    summarize;
  end

  initial begin
    n_fail = 0;
    cmp_count = 0;
    srst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    mode = `FCL_MODE_NS;
    secured = 1'b0;
    backdoor_key = 64'h1112_1113_1114_1115;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset_nodiv;
    t_index;
    t_busy;
    t_modes;
    t_prot;
    t_engine;
    summarize;
  end
endmodule // fcl_flash_seq_tb_top
